/* gpint_regs.svh */
// Purpose: Register offsets, reset values and counts of the GPIO port block
// Assumes: Byte offsets within the slave's window, word aligned
// Notes:   Definitions only; included by the port module and the bench
`ifndef GPINT_REGS_SVH
`define GPINT_REGS_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define GPINT_DIR   8'h00
`define GPINT_MASK  8'h04
`define GPINT_PIN   8'h08
`define GPINT_MPIN  8'h0C
`define GPINT_SET   8'h10
`define GPINT_CLR   8'h14
`define GPINT_TGL   8'h18
`define GPINT_PSEL0 8'h20
`define GPINT_PSEL1 8'h24
`define GPINT_ISEL  8'h28
`define GPINT_IENR  8'h2C
`define GPINT_IENF  8'h30
`define GPINT_IST   8'h34
`define GPINT_GPOL  8'h38
`define GPINT_GENA  8'h3C

// ----------------------------------------
// Reset values and counts
// ----------------------------------------
`define GPINT_RST_ZERO 32'h00000000
`define GPINT_RST_OE_N 32'hFFFFFFFF
`define GPINT_CHANNELS 8
`define GPINT_SEL_W    5

`endif

/* gpint_pkg.sv */
// Purpose: Types shared by the GPIO port block
// Assumes: gpint_regs.svh supplies the numbers
// Notes:   Address phase of an AHB-Lite transfer travels as one struct
`default_nettype none

package gpint_pkg;
  // Captured address phase, consumed in the following data phase
  typedef struct packed {
    logic valid;
    logic wr;
    logic [7:0] off;
    logic [3:0] be;
  } gpint_aph_t;
endpackage

`default_nettype wire

/* gpint_port.sv */
// Purpose: GPIO port with set/clear/mask access and eight pin interrupts
// Assumes: AHB-Lite slave, zero wait states, pins synchronous to nothing
// Notes:   One port of up to 32 pins; instantiate several for more pins
`include "gpint_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module gpint_port
  import gpint_pkg::*;
#(
  parameter int PINS = 32
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic [PINS-1:0] pin_in,
  output logic [PINS-1:0] pin_out,
  output logic [PINS-1:0] pin_oe_n,
  output logic [7:0] pint_irq,
  output logic grp_irq
);

  // Bits above PINS are not implemented and read as zero
  localparam logic [31:0] VALID =
    (PINS >= 32) ? 32'hFFFFFFFF : ((32'h1 << PINS) - 32'h1);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // Byte enables expanded to a 32-bit lane mask
  function automatic logic [31:0] lanes(input logic [3:0] be);
    lanes = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  endfunction

  // Merge written data into old value on enabled lanes only
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] wd,
                                        input logic [31:0] lm);
    merge = (old & ~lm) | (wd & lm);
  endfunction

  // ----------------------------------------
  // Input synchroniser
  // ----------------------------------------
  logic [31:0] pin_s1;
  logic [31:0] pin_s2;

  // Two stages; only pin_s2 is looked at by the rest of the block
  // Costs two cycles of input lag but keeps metastable values out
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_s1 <= `GPINT_RST_ZERO;
      pin_s2 <= `GPINT_RST_ZERO;
    end else begin
      pin_s1 <= 32'(pin_in);
      pin_s2 <= pin_s1;
    end
  end

  // ----------------------------------------
  // State and next values
  // ----------------------------------------
  gpint_aph_t aph;
  gpint_aph_t next_aph;
  logic [31:0] dir, next_dir;
  logic [31:0] mask, next_mask;
  logic [31:0] outv, next_outv;
  logic [63:0] psel, next_psel;
  logic [7:0] isel, next_isel;
  logic [7:0] ienr, next_ienr;
  logic [7:0] ienf, next_ienf;
  logic [7:0] ist, next_ist;
  logic [31:0] gpol, next_gpol;
  logic [31:0] gena, next_gena;
  logic [7:0] chan_prev;
  logic [7:0] chan_now;
  logic [7:0] edge_set;
  logic [7:0] lvl_hit;
  logic grp_hit;
  logic [31:0] next_hrdata;
  logic [31:0] lm;
  logic [31:0] wsel;
  logic [3:0] be;

  // Channel sampling straight off the synchronised pad, not the mux
  // A new selector can show one false edge; clear flags after it
  always_comb begin
    for (int i = 0; i < `GPINT_CHANNELS; i++) begin
      chan_now[i] = pin_s2[psel[8*i +: `GPINT_SEL_W]];
      edge_set[i] = !isel[i] &&
        ((ienr[i] && chan_now[i] && !chan_prev[i]) ||
         (ienf[i] && !chan_now[i] && chan_prev[i]));
      lvl_hit[i] = isel[i] && ienr[i] &&
        (chan_now[i] == ienf[i]);
    end
    // Pin counts toward the group when it sits at its chosen polarity
    grp_hit = |(gena & VALID & ~(pin_s2 ^ gpol));
  end

  // Byte enables from size and low address bits
  always_comb begin
    unique case (hsize)
      3'h0: be = 4'h1 << haddr[1:0];
      3'h1: be = haddr[1] ? 4'hC : 4'h3;
      default: be = 4'hF;
    endcase
  end

  // Register file next state; data phase write, then hardware events
  always_comb begin
    next_aph.valid = hsel && htrans[1] && hready;
    next_aph.wr = hwrite;
    next_aph.off = {haddr[7:2], 2'h0};
    next_aph.be = be;
    next_dir = dir;
    next_mask = mask;
    next_outv = outv;
    next_psel = psel;
    next_isel = isel;
    next_ienr = ienr;
    next_ienf = ienf;
    next_gpol = gpol;
    next_gena = gena;
    lm = lanes(aph.be);
    wsel = hwdata & lm;
    next_ist = ist;
    if (aph.valid && aph.wr) begin
      unique case (aph.off)
        `GPINT_DIR: next_dir = merge(dir, hwdata, lm) & VALID;
        `GPINT_MASK: next_mask = merge(mask, hwdata, lm) & VALID;
        `GPINT_PIN: next_outv = merge(outv, hwdata, lm) & VALID;
        `GPINT_MPIN: next_outv = merge(outv, hwdata, lm & mask);
        `GPINT_SET: next_outv = (outv | wsel) & VALID;
        `GPINT_CLR: next_outv = outv & ~wsel;
        `GPINT_TGL: next_outv = (outv ^ wsel) & VALID;
        `GPINT_PSEL0: next_psel[31:0] = merge(psel[31:0], hwdata, lm);
        `GPINT_PSEL1: next_psel[63:32] = merge(psel[63:32], hwdata, lm);
        `GPINT_ISEL: next_isel = 8'(merge({24'h0, isel}, hwdata, lm));
        `GPINT_IENR: next_ienr = 8'(merge({24'h0, ienr}, hwdata, lm));
        `GPINT_IENF: next_ienf = 8'(merge({24'h0, ienf}, hwdata, lm));
        `GPINT_IST: next_ist = ist & ~wsel[7:0]; // write one to clear
        `GPINT_GPOL: next_gpol = merge(gpol, hwdata, lm) & VALID;
        `GPINT_GENA: next_gena = merge(gena, hwdata, lm) & VALID;
        default: ; // unmapped writes are dropped
      endcase
    end
    // Selector only needs the low bits of each byte
    for (int i = 0; i < `GPINT_CHANNELS; i++) begin
      next_psel[8*i+5 +: 3] = 3'h0;
    end
    // New edge wins over a clear in the same cycle
    next_ist = next_ist | edge_set;
  end

  // Read data taken from next values so a write just before is visible
  always_comb begin
    next_hrdata = `GPINT_RST_ZERO;
    if (next_aph.valid && !hwrite) begin
      unique case (next_aph.off)
        `GPINT_DIR: next_hrdata = next_dir;
        `GPINT_MASK: next_hrdata = next_mask;
        `GPINT_PIN: next_hrdata = pin_s2;
        `GPINT_MPIN: next_hrdata = pin_s2 & next_mask;
        `GPINT_SET: next_hrdata = next_outv;
        `GPINT_CLR: next_hrdata = next_outv;
        `GPINT_TGL: next_hrdata = next_outv;
        `GPINT_PSEL0: next_hrdata = next_psel[31:0];
        `GPINT_PSEL1: next_hrdata = next_psel[63:32];
        `GPINT_ISEL: next_hrdata = {24'h0, next_isel};
        `GPINT_IENR: next_hrdata = {24'h0, next_ienr};
        `GPINT_IENF: next_hrdata = {24'h0, next_ienf};
        `GPINT_IST: next_hrdata = {24'h0, next_ist | lvl_hit};
        `GPINT_GPOL: next_hrdata = next_gpol;
        `GPINT_GENA: next_hrdata = next_gena;
        default: next_hrdata = `GPINT_RST_ZERO;
      endcase
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  // Zero wait states: the slave never stretches, answers OKAY
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      aph <= '0;
      dir <= `GPINT_RST_ZERO;
      mask <= `GPINT_RST_ZERO;
      outv <= `GPINT_RST_ZERO;
      psel <= 64'h0;
      isel <= 8'h00;
      ienr <= 8'h00;
      ienf <= 8'h00;
      ist <= 8'h00;
      gpol <= `GPINT_RST_ZERO;
      gena <= `GPINT_RST_ZERO;
      chan_prev <= 8'h00;
      hrdata <= `GPINT_RST_ZERO;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      pin_out <= '0;
      pin_oe_n <= PINS'(`GPINT_RST_OE_N);
      pint_irq <= 8'h00;
      grp_irq <= 1'b0;
    end else begin
      aph <= next_aph;
      dir <= next_dir;
      mask <= next_mask;
      outv <= next_outv;
      psel <= next_psel;
      isel <= next_isel;
      ienr <= next_ienr;
      ienf <= next_ienf;
      ist <= next_ist;
      gpol <= next_gpol;
      gena <= next_gena;
      chan_prev <= chan_now;
      hrdata <= next_hrdata;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      pin_out <= next_outv[PINS-1:0];
      pin_oe_n <= ~next_dir[PINS-1:0];
      pint_irq <= next_ist | lvl_hit;
      grp_irq <= grp_hit;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  // Full-word data phase writes, the case eight of the checks below look at
  logic dp_wr;
  assign dp_wr = aph.valid && aph.wr && aph.be == 4'hF;

  // Pad sampling and port access
  AST_SYNC_TWO: assert property (@(posedge hclk)
    disable iff (!hresetn) pin_s2[PINS-1:0] == $past(pin_in, 2))
    else $error("pin sample not two stages behind pad");
  AST_SET_HIGH: assert property (@(posedge hclk)
    disable iff (!hresetn) dp_wr && aph.off == `GPINT_SET |=>
    (pin_out & $past(hwdata[PINS-1:0])) == $past(hwdata[PINS-1:0]))
    else $error("set write did not raise bits");
  AST_SET_KEEP: assert property (@(posedge hclk)
    disable iff (!hresetn) dp_wr && aph.off == `GPINT_SET |=>
    ((pin_out ^ $past(pin_out)) & ~$past(hwdata[PINS-1:0])) == '0)
    else $error("set write touched zero bits");
  AST_CLR_LOW: assert property (@(posedge hclk)
    disable iff (!hresetn) dp_wr && aph.off == `GPINT_CLR |=>
    (pin_out & $past(hwdata[PINS-1:0])) == '0)
    else $error("clear write did not lower bits");
  AST_CLR_KEEP: assert property (@(posedge hclk)
    disable iff (!hresetn) dp_wr && aph.off == `GPINT_CLR |=>
    ((pin_out ^ $past(pin_out)) & ~$past(hwdata[PINS-1:0])) == '0)
    else $error("clear write touched zero bits");
  AST_PIN_FULL: assert property (@(posedge hclk)
    disable iff (!hresetn) dp_wr && aph.off == `GPINT_PIN |=>
    pin_out == $past(hwdata[PINS-1:0]))
    else $error("full write did not set whole output");
  AST_TGL_FLIP: assert property (@(posedge hclk)
    disable iff (!hresetn) dp_wr && aph.off == `GPINT_TGL |=>
    pin_out == ($past(pin_out) ^ $past(hwdata[PINS-1:0])))
    else $error("toggle write flipped wrong bits");
  AST_MASK_KEEP: assert property (@(posedge hclk)
    disable iff (!hresetn) aph.valid && aph.wr && aph.off == `GPINT_MPIN |=>
    ((pin_out ^ $past(pin_out)) & ~$past(mask[PINS-1:0])) == '0)
    else $error("masked write changed excluded bit");
  AST_MPIN_TAKE: assert property (@(posedge hclk)
    disable iff (!hresetn) dp_wr && aph.off == `GPINT_MPIN |=>
    ((pin_out ^ $past(hwdata[PINS-1:0])) & $past(mask[PINS-1:0])) == '0)
    else $error("masked write missed included bit");
  AST_BYTE_LANE: assert property (@(posedge hclk)
    disable iff (!hresetn) aph.valid && aph.wr && aph.be != 4'hF &&
    aph.off == `GPINT_PIN |=>
    ((pin_out ^ $past(pin_out)) & ~$past(lm[PINS-1:0])) == '0)
    else $error("narrow write changed other lanes");
  AST_DIR_OE: assert property (@(posedge hclk)
    disable iff (!hresetn) dp_wr && aph.off == `GPINT_DIR |=>
    pin_oe_n == ~$past(hwdata[PINS-1:0]))
    else $error("direction write not seen on enables");
  AST_PIN_READ: assert property (@(posedge hclk)
    disable iff (!hresetn) hsel && htrans[1] && hready && !hwrite &&
    haddr[7:0] == `GPINT_PIN |=> hrdata == $past(pin_s2))
    else $error("pin read not current level");
  AST_RD_IDLE: assert property (@(posedge hclk)
    disable iff (!hresetn) !(hsel && htrans[1] && hready && !hwrite) |=>
    hrdata == 32'h00000000)
    else $error("read data not cleared outside read");
  AST_ONE_CYCLE: assert property (@(posedge hclk)
    disable iff (!hresetn) hreadyout && !hresp)
    else $error("slave inserted wait or error");

  // Interrupt requests
  AST_EDGE_FLAG: assert property (@(posedge hclk)
    disable iff (!hresetn) edge_set != 8'h00 |=>
    (pint_irq & $past(edge_set)) == $past(edge_set))
    else $error("edge did not raise request");
  AST_IST_HOLD: assert property (@(posedge hclk)
    disable iff (!hresetn) !(aph.valid && aph.wr && aph.off == `GPINT_IST) |=>
    (ist & $past(ist)) == $past(ist))
    else $error("edge flag lost without a clear");
  AST_LEVEL: assert property (@(posedge hclk)
    disable iff (!hresetn) lvl_hit != 8'h00 |=>
    (pint_irq & $past(lvl_hit)) == $past(lvl_hit))
    else $error("level channel not requesting");
  AST_REQ_OWN: assert property (@(posedge hclk)
    disable iff (!hresetn)
    (pint_irq & ~$past(ist | edge_set | lvl_hit)) == 8'h00)
    else $error("request without a cause on its channel");
  AST_GROUP: assert property (@(posedge hclk)
    disable iff (!hresetn) grp_hit |=> grp_irq)
    else $error("group interrupt missing");
  AST_GRP_QUIET: assert property (@(posedge hclk)
    disable iff (!hresetn) !grp_hit |=> !grp_irq)
    else $error("group interrupt without a match");

endmodule

`default_nettype wire

/* gpint_pads.sv */
// Purpose: Board-side model of the port pins
// Assumes: Board source is weak, the port wins where it drives
// Notes:   Undriven pins show whatever level the bench sets on the board
`timescale 1ns/1ps
`default_nettype none

module gpint_pads (
  input wire logic [31:0] pin_out,
  input wire logic [31:0] pin_oe_n,
  input wire logic [31:0] ext_lvl,
  output logic [31:0] pin_in
);
  // Pad level per bit: port level when driven, board level otherwise
  assign pin_in = (pin_out & ~pin_oe_n) | (ext_lvl & pin_oe_n);
endmodule

`default_nettype wire

/* gpint_tb.sv */
// Purpose: Self-checking bench of the GPIO port block
// Assumes: One AHB-Lite slave, hready tied to hreadyout
// Notes:   Pin checks sample at the falling edge, where outputs have settled
`include "gpint_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module tb;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b1;
  logic hwrite = 1'b0;
  logic hready;
  logic hreadyout;
  logic hresp;
  logic grp_irq;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic [31:0] ext_lvl = 32'h0;
  logic [31:0] pin_in;
  logic [31:0] pin_out;
  logic [31:0] pin_oe_n;
  logic [7:0] pint_irq;
  int miscompares = 0;
  int num_checks = 0;

  // ----------------------------------------
  // Clock, bus tie and instances
  // ----------------------------------------
  always #12.5 hclk = ~hclk;
  assign hready = hreadyout;

  gpint_port #(.PINS(32)) i_dut (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
    .pint_irq(pint_irq), .grp_irq(grp_irq));

  gpint_pads i_pads (.pin_out(pin_out), .pin_oe_n(pin_oe_n),
    .ext_lvl(ext_lvl), .pin_in(pin_in));

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One transfer, entered just after a rising edge; no wait count assumed
  task ahb(input logic wr, input logic [7:0] a, input logic [2:0] sz,
           input logic [31:0] wd, output logic [31:0] rd);
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= wr;
    hsize <= sz;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    // Read before the edge's updates land: the data that stood up to it
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
  endtask

  task w(input logic [7:0] a, input logic [31:0] d,
         input logic [2:0] sz = 3'h2);
    logic [31:0] x;
    ahb(1'b1, a, sz, d, x);
  endtask

  task r(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] x;
    ahb(1'b0, a, 3'h2, 32'h0, x);
    chk(x, e);
  endtask

  task wait_n(input int n);
    repeat (n) @(posedge hclk);
  endtask

  task pads(input logic [31:0] v);
    ext_lvl <= v;
  endtask

  // Pin outputs, looked at mid-cycle
  task cp(input logic [31:0] eo, input logic [31:0] en);
    @(negedge hclk);
    chk(pin_out, eo);
    chk(pin_oe_n, en);
    @(posedge hclk);
  endtask

  // Requests after the synchroniser and detection lag
  task ci(input logic [8:0] e);
    wait_n(4);
    @(negedge hclk);
    chk({23'h0, grp_irq, pint_irq}, {23'h0, e});
    @(posedge hclk);
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task t_reset;
    cp(32'h0, 32'hFFFFFFFF);
    @(negedge hclk);
    chk({30'h0, hreadyout, hresp}, 32'h00000002);
    @(posedge hclk);
    r(`GPINT_DIR, 32'h0);
    r(8'h1C, 32'h0);
    $display("test reset done");
  endtask

  // Direction, full write, set/clear, lanes and mask, back to back
  task t_port;
    pads(32'hC0000000);
    w(`GPINT_DIR, 32'h0000FFFF);
    w(`GPINT_PIN, 32'hA5A55A5A);
    cp(32'hA5A55A5A, 32'hFFFF0000);
    wait_n(3);
    r(`GPINT_PIN, 32'hC0005A5A);
    w(`GPINT_SET, 32'h00000130);
    w(`GPINT_CLR, 32'h00000202);
    cp(32'hA5A55978, 32'hFFFF0000);
    w(`GPINT_PIN + 8'h01, 32'h00003C00, 3'h0);
    w(`GPINT_PIN + 8'h02, 32'h12340000, 3'h1);
    cp(32'h12343C78, 32'hFFFF0000);
    w(`GPINT_MASK, 32'h000000F0);
    w(`GPINT_MPIN, 32'hFFFF00A0);
    cp(32'h12343CA8, 32'hFFFF0000);
    wait_n(3);
    r(`GPINT_MPIN, 32'h000000A0);
    w(`GPINT_DIR, 32'h0);
    cp(32'h12343CA8, 32'hFFFFFFFF);
    w(`GPINT_TGL, 32'h0000000F);
    cp(32'h12343CA7, 32'hFFFFFFFF);
    r(`GPINT_TGL, 32'h12343CA7);
    $display("test port done");
  endtask

  // Edge, level and group requests from pin 20 and pins 21, 22
  task t_irq;
    w(`GPINT_PSEL0, 32'h14141414);
    w(`GPINT_PSEL1, 32'h00000014);
    w(`GPINT_IENR, 32'h00000005);
    w(`GPINT_IENF, 32'h00000006);
    pads(32'hC0100000);
    ci(9'h005);
    w(`GPINT_IST, 32'h00000007);
    ci(9'h000);
    pads(32'hC0000000);
    ci(9'h006);
    w(`GPINT_IST, 32'h00000007);
    w(`GPINT_ISEL, 32'h00000018);
    w(`GPINT_IENR, 32'h00000018);
    w(`GPINT_IENF, 32'h00000008);
    r(`GPINT_IENR, 32'h00000018);
    ci(9'h010);
    pads(32'hC0500000);
    w(`GPINT_GENA, 32'h00600000);
    w(`GPINT_GPOL, 32'h00200000);
    ci(9'h008);
    pads(32'hC0700000);
    ci(9'h108);
    $display("test interrupts done");
  endtask

  task test_done;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------
  initial begin
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_reset;
    t_port;
    t_irq;
    test_done;
  end

  // Whole run needs about a hundred cycles; a hang costs at most 3000
  initial begin
    #75000;
    miscompares++;
    test_done;
  end
endmodule

`default_nettype wire
